// ==== rtl/rotate_subtract_sleep_exec.v ====
// execution datapath: rotate through carry, literal minus accumulator, halt
// assumes one instruction strobe per cycle from the core decoder on ref_clk
// Summary of operation
// RULE1: rotate left: bits move up, carry into bit 0, bit 7 to carry.
// RULE2: rotate result goes to accumulator if destination 0, file register if 1.
// RULE3: rotate right: carry into bit 7, bit 0 to carry; only carry changes.
// RULE4: halt clears the watchdog counter and its prescaler to zero.
// RULE5: halt clears powerdown flag, sets watchdog expiry flag; other flags untouched.
// RULE6: after halt, oscillator stops and no further instructions execute.
// RULE7: literal minus accumulator, two's complement, result always to accumulator.
// RULE8: carry set when acc <= literal; nibble carry same on low nibbles.
// RULE9: zero flag set when subtraction result is zero, else cleared.
// RULE10: rotate operand is a 7-bit file address in the selected bank.
`include "rotsub_consts.vh"
module rotate_subtract_sleep_exec (
  input wire ref_clk,
  input wire resetn,
  input wire opValid,
  input wire [1:0] opSel,
  input wire haltOp,
  input wire destBit,
  input wire [6:0] fileAddrIn,
  input wire [7:0] fileReadData,
  input wire [7:0] literal,
  input wire wakeEvent,
  output reg [7:0] acc,
  output reg carryFlag,
  output reg nibble_carry_flag,
  output reg zeroFlag,
  output reg watchdog_expiry_flag,
  output reg powerdown_flag,
  output reg [7:0] watchdog_counter,
  output reg [7:0] watchdogPrescaler,
  output reg fileWriteEn,
  output reg [6:0] fileWriteAddr,
  output reg [7:0] fileWriteData,
  output reg oscRun,
  output reg halted
);
  // run and halt are the only two core states seen by this block
  localparam RUN_STATE = 1'h0;
  localparam HALT_STATE = 1'h1;
  reg coreState;
  reg next_coreState;
  reg wakeMeta;
  reg wakeSync;
  reg [7:0] next_acc;
  reg next_carryFlag;
  reg next_nibble_carry_flag;
  reg next_zeroFlag;
  reg next_watchdog_expiry_flag;
  reg next_powerdown_flag;
  reg [7:0] next_watchdog_counter;
  reg [7:0] next_watchdogPrescaler;
  reg next_fileWriteEn;
  reg [6:0] next_fileWriteAddr;
  reg [7:0] next_fileWriteData;
  reg next_oscRun;
  reg next_halted;
  wire [7:0] aluResult;
  wire aluCarry;
  wire aluNibble;
  wire aluZero;
  wire accept;
  wire isRotate;
  wire isSubtract;
  wire prescWrap;

  // once halted, every strobe is ignored until a wake event releases the core
  assign accept = opValid & (coreState == RUN_STATE); // [RULE6]
  assign isRotate = (opSel == `OPC_ROT_LEFT) | (opSel == `OPC_ROT_RIGHT); // [RULE1] [RULE3]
  assign isSubtract = (opSel == `OPC_LIT_SUB); // [RULE7]
  assign prescWrap = (watchdogPrescaler == `PRESC_WRAP);

  rotsub_alu alu (
    .opSel(opSel),
    .fileData(fileReadData),
    .acc(acc),
    .literal(literal),
    .carryIn(carryFlag),
    .result(aluResult),
    .carryOut(aluCarry),
    .nibbleCarry(aluNibble),
    .zero(aluZero)
  );

  // wake arrives from the oscillator-independent domain, so synchronise it
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wakeMeta <= `SYNC_RESET;
      wakeSync <= `SYNC_RESET;
    end
    else
    begin
      wakeMeta <= wakeEvent;
      wakeSync <= wakeMeta;
    end
  end

  // datapath: halt in the same strobe wins, so no operand is consumed then
  always @*
  begin
    next_acc = acc;
    next_carryFlag = carryFlag;
    next_nibble_carry_flag = nibble_carry_flag;
    next_zeroFlag = zeroFlag;
    next_fileWriteEn = 1'h0;
    next_fileWriteAddr = fileWriteAddr;
    next_fileWriteData = fileWriteData;
    if (accept && !haltOp)
    begin
      if (isRotate)
      begin
        // rotates touch carry only; the other flags keep their value
        next_carryFlag = aluCarry; // [RULE3]
        if (destBit == `DEST_ACC)
        begin
          next_acc = aluResult; // [RULE2]
        end
        else
        begin
          // write strobe lasts one cycle; address and data hold until the next write
          next_fileWriteEn = 1'h1; // [RULE2]
          next_fileWriteAddr = fileAddrIn & `ADDR_MASK; // [RULE10]
          next_fileWriteData = aluResult; // [RULE2]
        end
      end
      else if (isSubtract)
      begin
        next_acc = aluResult; // [RULE7]
        next_carryFlag = aluCarry; // [RULE8]
        next_nibble_carry_flag = aluNibble; // [RULE8]
        next_zeroFlag = aluZero; // [RULE9]
      end
    end
  end

  // power state: watchdog runs only while the oscillator runs
  always @*
  begin
    next_coreState = coreState;
    next_halted = halted;
    next_oscRun = oscRun;
    next_watchdog_expiry_flag = watchdog_expiry_flag;
    next_powerdown_flag = powerdown_flag;
    next_watchdog_counter = watchdog_counter;
    next_watchdogPrescaler = watchdogPrescaler;
    case (coreState)
      RUN_STATE:
      begin
        if (accept && haltOp)
        begin
          next_watchdog_counter = `WDOG_CLEAR; // [RULE4]
          next_watchdogPrescaler = `PRESC_CLEAR; // [RULE4]
          next_powerdown_flag = `FLAG_PWRDN_HALT; // [RULE5]
          next_watchdog_expiry_flag = `FLAG_EXPIRY_HALT; // [RULE5]
          next_oscRun = 1'h0; // [RULE6]
          next_halted = 1'h1; // [RULE6]
          next_coreState = HALT_STATE; // [RULE6]
        end
        else
        begin
          next_watchdogPrescaler = watchdogPrescaler + 8'h01;
          if (prescWrap)
          begin
            next_watchdog_counter = watchdog_counter + 8'h01;
          end
        end
      end
      HALT_STATE:
      begin
        // counters stay frozen while the oscillator is stopped
        if (wakeSync)
        begin
          next_oscRun = 1'h1;
          next_halted = 1'h0;
          next_coreState = RUN_STATE;
        end
      end
    endcase
  end

  // datapath registers
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc <= `ACC_RESET;
      carryFlag <= `CARRY_RESET;
      nibble_carry_flag <= `NIBBLE_RESET;
      zeroFlag <= `ZERO_RESET;
      fileWriteEn <= `WE_RESET;
      fileWriteAddr <= `WADDR_RESET;
      fileWriteData <= `WDATA_RESET;
    end
    else
    begin
      acc <= next_acc;
      carryFlag <= next_carryFlag;
      nibble_carry_flag <= next_nibble_carry_flag;
      zeroFlag <= next_zeroFlag;
      fileWriteEn <= next_fileWriteEn;
      fileWriteAddr <= next_fileWriteAddr;
      fileWriteData <= next_fileWriteData;
    end
  end

  // power and watchdog registers
  always @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      coreState <= RUN_STATE;
      halted <= `HALTED_RESET;
      oscRun <= `OSC_RESET;
      watchdog_expiry_flag <= `FLAG_EXPIRY_RESET;
      powerdown_flag <= `FLAG_PWRDN_RESET;
      watchdog_counter <= `WDOG_CLEAR;
      watchdogPrescaler <= `PRESC_CLEAR;
    end
    else
    begin
      coreState <= next_coreState;
      halted <= next_halted;
      oscRun <= next_oscRun;
      watchdog_expiry_flag <= next_watchdog_expiry_flag;
      powerdown_flag <= next_powerdown_flag;
      watchdog_counter <= next_watchdog_counter;
      watchdogPrescaler <= next_watchdogPrescaler;
    end
  end
endmodule

// ==== rtl/rotsub_consts.vh ====
// constants for the rotate/subtract/halt execution datapath
// assumes inclusion by its bare name from rtl/ design files
`ifndef ROTSUB_CONSTS_VH
`define ROTSUB_CONSTS_VH
`define OPC_NONE 2'h0
`define OPC_ROT_LEFT 2'h1
`define OPC_ROT_RIGHT 2'h2
`define OPC_LIT_SUB 2'h3
`define DEST_ACC 1'h0
`define DEST_FILE 1'h1
`define ACC_RESET 8'h00
`define WDOG_CLEAR 8'h00
`define PRESC_CLEAR 8'h00
`define FLAG_EXPIRY_RESET 1'h1
`define FLAG_PWRDN_RESET 1'h1
`define ADDR_MASK 7'h7F
`define CARRY_RESET 1'h0
`define NIBBLE_RESET 1'h0
`define ZERO_RESET 1'h0
`define WE_RESET 1'h0
`define WADDR_RESET 7'h00
`define WDATA_RESET 8'h00
`define OSC_RESET 1'h1
`define HALTED_RESET 1'h0
`define SYNC_RESET 1'h0
`define PRESC_WRAP 8'hFF
`define FLAG_PWRDN_HALT 1'h0
`define FLAG_EXPIRY_HALT 1'h1
`endif

// ==== rtl/rotsub_alu.v ====
// combinational rotate and literal-subtract unit
// assumes operands are stable inputs from the same clock domain
`include "rotsub_consts.vh"
module rotsub_alu (
  input wire [1:0] opSel,
  input wire [7:0] fileData,
  input wire [7:0] acc,
  input wire [7:0] literal,
  input wire carryIn,
  output reg [7:0] result,
  output reg carryOut,
  output reg nibbleCarry,
  output reg zero
);
  reg [8:0] diff;
  reg [4:0] lowDiff;
  always @*
  begin
    diff = {1'h0, literal} + {1'h0, ~acc} + 9'h001;
    lowDiff = {1'h0, literal[3:0]} + {1'h0, ~acc[3:0]} + 5'h01;
    result = fileData;
    carryOut = carryIn;
    nibbleCarry = 1'h0;
    zero = 1'h0;
    case (opSel)
      `OPC_ROT_LEFT:
      begin
        result = {fileData[6:0], carryIn}; // [RULE1]
        carryOut = fileData[7]; // [RULE1]
      end
      `OPC_ROT_RIGHT:
      begin
        result = {carryIn, fileData[7:1]}; // [RULE3]
        carryOut = fileData[0]; // [RULE3]
      end
      `OPC_LIT_SUB:
      begin
        result = diff[7:0]; // [RULE7]
        carryOut = diff[8]; // [RULE8]
        nibbleCarry = lowDiff[4]; // [RULE8]
        zero = (diff[7:0] == 8'h00); // [RULE9]
      end
      default:
      begin
        result = fileData;
      end
    endcase
  end
endmodule

// ==== verif/rotsub_assertions.sv ====
// checker for the rotate/subtract/halt datapath
// assumes bind to the top module ports
module rotsub_checker (
  input ref_clk,
  input resetn,
  input opValid,
  input [1:0] opSel,
  input haltOp,
  input destBit,
  input [6:0] fileAddrIn,
  input [7:0] fileReadData,
  input [7:0] literal,
  input [7:0] acc,
  input carryFlag,
  input nibble_carry_flag,
  input zeroFlag,
  input watchdog_expiry_flag,
  input powerdown_flag,
  input [7:0] watchdog_counter,
  input [7:0] watchdogPrescaler,
  input fileWriteEn,
  input [6:0] fileWriteAddr,
  input [7:0] fileWriteData,
  input oscRun,
  input halted
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire go = opValid && !halted && !haltOp;
  wire hlt = opValid && !halted && haltOp;
  chk_halt_flags: assert property (hlt |=> halted && !oscRun && !powerdown_flag && watchdog_expiry_flag)
    else $error("halt flags");
  chk_wdog_zero: assert property (hlt |=> watchdog_counter == 8'h00 && watchdogPrescaler == 8'h00)
    else $error("watchdog not cleared");
  chk_halt_refuse: assert property (halted && opValid |=> $stable(acc) && !fileWriteEn)
    else $error("op ran in halt");
  chk_rol_acc: assert property (go && opSel == 2'h1 && !destBit |=>
    acc == {$past(fileReadData[6:0]), $past(carryFlag)} && carryFlag == $past(fileReadData[7])) else $error("rol");
  chk_ror_file: assert property (go && opSel == 2'h2 && destBit |=> fileWriteEn &&
    fileWriteData == {$past(carryFlag), $past(fileReadData[7:1])} && carryFlag == $past(fileReadData[0])
    && fileWriteAddr == $past(fileAddrIn)) else $error("ror");
  chk_rot_dest: assert property (go && ^opSel |=> $stable(zeroFlag) &&
    ($past(destBit) ? $stable(acc) : !fileWriteEn)) else $error("rotate destination");
  chk_sub_result: assert property (go && opSel == 2'h3 |=>
    acc == $past(literal) - $past(acc) && !fileWriteEn) else $error("subtract result");
  chk_sub_flags: assert property (go && opSel == 2'h3 |=> carryFlag == ($past(acc) <= $past(literal)) &&
    nibble_carry_flag == ($past(acc[3:0]) <= $past(literal[3:0])) && zeroFlag == ($past(acc) == $past(literal)))
    else $error("subtract flags");
endmodule

// ==== verif/rotate_subtract_sleep_exec_tb.sv ====
// self-checking bench for the rotate/subtract/halt datapath
// assumes the checker file is compiled first
module rotate_subtract_sleep_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = '0, resetn = '0, opValid = '0, haltOp = '0, destBit = '0, wakeEvent = '0;
  logic [1:0] opSel = '0;
  logic [6:0] fileAddrIn = '0;
  logic [7:0] fileReadData = '0, literal = '0;
  wire [7:0] acc, watchdog_counter, watchdogPrescaler, fileWriteData;
  wire [6:0] fileWriteAddr;
  wire carryFlag, nibble_carry_flag, zeroFlag, watchdog_expiry_flag, powerdown_flag, fileWriteEn, oscRun, halted;
  int n_mismatch = 0, checks_done = 0, cycles = 0;
  // op, dest, file data, literal, result, carry, nibble carry, zero; state chains row to row
  logic [29:0] rows [9] = '{{2'h1, 1'h0, 8'hE6, 8'h00, 8'hCC, 1'h1, 1'h0, 1'h0},
    {2'h3, 1'h0, 8'h00, 8'h05, 8'h39, 1'h0, 1'h0, 1'h0}, {2'h2, 1'h0, 8'h81, 8'h00, 8'h40, 1'h1, 1'h0, 1'h0},
    {2'h1, 1'h0, 8'h01, 8'h00, 8'h03, 1'h0, 1'h0, 1'h0}, {2'h3, 1'h0, 8'h00, 8'h03, 8'h00, 1'h1, 1'h1, 1'h1},
    {2'h2, 1'h1, 8'h01, 8'h00, 8'h80, 1'h1, 1'h1, 1'h1}, {2'h3, 1'h0, 8'h00, 8'h13, 8'h13, 1'h1, 1'h1, 1'h0},
    {2'h3, 1'h0, 8'h00, 8'h22, 8'h0F, 1'h1, 1'h0, 1'h0}, {2'h1, 1'h1, 8'h80, 8'h00, 8'h01, 1'h1, 1'h0, 1'h0}};
  rotate_subtract_sleep_exec DUT (.*);
  initial forever #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (++cycles == 400)
    begin
      n_mismatch++;
      wrap_up();
    end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    #1 resetn = '1;
    // back to back, one op per cycle
    foreach (rows[i])
    begin
      {opSel, destBit, fileReadData, literal} = rows[i][29:11];
      fileAddrIn = ~fileReadData[6:0];
      opValid = '1;
      @(posedge ref_clk) #1;
      chk(destBit ? fileWriteData : acc, rows[i][10:3]);
      chk(fileWriteEn, destBit);
      chk(carryFlag, rows[i][2]);
      chk({nibble_carry_flag, zeroFlag}, rows[i][1:0]);
      if (destBit) chk(fileWriteAddr, fileAddrIn);
    end
    $display("table done");
    // halt beats a simultaneous subtract
    {haltOp, opSel, literal} = {1'h1, 2'h3, 8'hFF};
    @(posedge ref_clk) #1 haltOp = '0;
    chk({halted, oscRun, powerdown_flag, watchdog_expiry_flag, fileWriteEn}, 5'h12);
    chk(watchdog_counter | watchdogPrescaler, 8'h00);
    repeat (3) @(posedge ref_clk);
    #1 chk(acc, 8'h0F);
    {opValid, wakeEvent} = 2'h1;
    repeat (4) @(posedge ref_clk);
    #1 chk({halted, oscRun}, 2'h1);
    $display("halt done");
    resetn = '0;
    #2 chk(acc, 8'h00);
    chk({powerdown_flag, watchdog_expiry_flag, halted, fileWriteEn}, 4'hC);
    $display("reset done");
    wrap_up();
  end
endmodule
bind rotate_subtract_sleep_exec rotsub_checker u_chk (.*);
